// ==== sfmp_pkg.sv ====
// Constants shared by the serial flash mode and protect logic.
// Assumes one 200 MHz core clock; every time is turned into cycles here.
package sfmp_pkg;
	// Core clock period in picoseconds.
	localparam int unsigned CLK_PS       = 5000;
	// Opcodes recognised by the command filter.
	localparam logic [7:0]  OP_WRSR      = 8'h01;
	localparam logic [7:0]  OP_PP        = 8'h02;
	localparam logic [7:0]  OP_WRDI      = 8'h04;
	localparam logic [7:0]  OP_RDSR1     = 8'h05;
	localparam logic [7:0]  OP_WREN      = 8'h06;
	localparam logic [7:0]  OP_SE        = 8'h20;
	localparam logic [7:0]  OP_QPP       = 8'h32;
	localparam logic [7:0]  OP_RDSR2     = 8'h35;
	localparam logic [7:0]  OP_EQPI      = 8'h38;
	localparam logic [7:0]  OP_RSTEN     = 8'h66;
	localparam logic [7:0]  OP_SUSP      = 8'h75;
	localparam logic [7:0]  OP_RESM      = 8'h7A;
	localparam logic [7:0]  OP_RST       = 8'h99;
	localparam logic [7:0]  OP_DPP       = 8'hA2;
	localparam logic [7:0]  OP_RDP       = 8'hAB;
	localparam logic [7:0]  OP_DPD       = 8'hB9;
	localparam logic [7:0]  OP_CE        = 8'hC7;
	localparam logic [7:0]  OP_BE        = 8'hD8;
	localparam logic [7:0]  OP_DQPI2     = 8'hF5;
	localparam logic [7:0]  OP_DQPI      = 8'hFF;
	// Kinds of array operation handed to the array sequencer.
	localparam logic [1:0]  OPK_PROG     = 2'h1;
	localparam logic [1:0]  OPK_ERASE    = 2'h2;
	localparam logic [1:0]  OPK_CHIP     = 2'h3;
	// Status byte layout and lane drive patterns.
	localparam logic [3:0]  RSVD_BITS    = 4'h0;
	localparam logic [3:0]  OE_SPI       = 4'h2;
	localparam logic [3:0]  OE_QPI       = 4'hF;
	// Protected span units: 256 kB blocks and 4 kB sectors.
	localparam logic [24:0] SPAN_BLOCK   = 25'h004_0000;
	localparam logic [24:0] SPAN_SECTOR  = 25'h000_1000;
	localparam logic [24:0] SPAN_SEC_MAX = 25'h000_8000;
	localparam logic [24:0] ARRAY_TOP    = 25'h100_0000;
	// Power-on reset window, in cycles.
	localparam logic [3:0]  POR_CYC      = 4'hF;
	// Operation times as printed, and their cycle counts.
	localparam int unsigned PUW_NS       = 1000000;
	localparam int unsigned PROG_NS      = 600000;
	localparam int unsigned ERASE_NS     = 60000000;
	localparam int unsigned CHIP_NS      = 400000000;
	localparam int unsigned WRSR_NS      = 10000000;
	localparam int unsigned PUW_CYC_DEF  = (PUW_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned PROG_CYC_DEF = (PROG_NS / 5);
	localparam int unsigned ERS_CYC_DEF  = (ERASE_NS / 5);
	localparam int unsigned CHIP_CYC_DEF = (CHIP_NS / 5);
	localparam int unsigned WRSR_CYC_DEF = (WRSR_NS / 5);
	// Frame phases of the command decoder.
	typedef enum logic [2:0] {
		PH_OPC = 3'b000,
		PH_ADR = 3'b001,
		PH_DAT = 3'b010,
		PH_RD  = 3'b011,
		PH_WT  = 3'b100,
		PH_IGN = 3'b101
	} sfmp_phase_e;
endpackage

// ==== sfmp_fifo.sv ====
// Program data FIFO between the serial front end and the array sequencer.
// Assumes one clock; flush empties it in one cycle and wins over a push.
`timescale 1ns/1ps
`default_nettype none
module sfmp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	// Storage words and pointers with one extra wrap bit.
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr;
	logic [AW:0]      rptr;
	wire              full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	wire              empty = (wptr == rptr);
	wire              push  = in_valid && !full && !flush;
	wire              pop   = out_ready && !empty && !flush;

	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rptr[AW-1:0]];

	// Storage write; no reset needed since empty guards reads.
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wptr[AW-1:0]] <= in_data;
	end

	// Pointer update; flush drops everything held.
	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			wptr <= '0;
			rptr <= '0;
		end
		else
		begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== sfmp_core.sv ====
// Mode and protection logic of a serial flash behind its SPI/quad pins.
// Assumes pins arrive asynchronous to mclk and the serial clock is far slower.
// Overview of operation
// [R1] Sample input lanes on serial clock rise.
// [R2] Change read output on serial clock fall.
// [R3] Accept modes 0 and 3 only.
// [R4] Dual commands move two bits per clock.
// [R5] Quad uses four lanes, needs quad enable.
// [R6] Four-lane mode entered by 38h with enable.
// [R7] Opcode eight clocks, or two in four-lane.
// [R8] Exactly one mode; disable commands leave four-lane.
// [R9] Power-up and 99h give single-lane mode.
// [R10] Power-on reset recognises no command.
// [R11] Power-up delay blocks all write commands.
// [R12] Write enable sets latch; writes need it.
// [R13] Latch clears after disable, program, erase, write.
// [R14] Deep power-down accepts only release command.
// [R15] Busy during operations; filters commands.
// [R16] Busy clears when operation completes.
// [R17] Reset enable then reset accepted while busy.
// [R18] Host waits for idle before resetting.
// [R19] First status byte layout.
// [R20] Second status byte layout.
// [R21] Guard bits select protected array part.
// [R22] Protect pin may gate status writes.
// [R23] Lock mode decodes four protection behaviours; here both slm values with slm[1] set give the same full lock.
// [R24] Suspend sets pause flag; resume clears.
// [R25] Top/bottom select picks range end.
// [R26] Mode change applies at frame end.
// [R27] Protected target leaves array and busy untouched.
`timescale 1ns/1ps
`default_nettype none
module sfmp_core #(
	parameter int unsigned PUW_CYC  = sfmp_pkg::PUW_CYC_DEF,
	parameter int unsigned PROG_CYC = sfmp_pkg::PROG_CYC_DEF,
	parameter int unsigned ERS_CYC  = sfmp_pkg::ERS_CYC_DEF,
	parameter int unsigned CHIP_CYC = sfmp_pkg::CHIP_CYC_DEF,
	parameter int unsigned WRSR_CYC = sfmp_pkg::WRSR_CYC_DEF
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       sck_pin,
	input  wire logic       cs_n_pin,
	input  wire logic [3:0] lane_in,
	output logic [3:0]      lane_out,
	output logic [3:0]      lane_oe,
	output logic            op_start,
	output logic [1:0]      op_kind,
	output logic [23:0]     op_addr,
	output logic [7:0]      prog_data,
	output logic            prog_valid,
	input  wire logic       prog_ready
);
	import sfmp_pkg::*;

	// Pin synchronisers; only s2 is read by logic.
	logic [5:0]  s1;
	logic [5:0]  s2;
	logic        sck_d;                  // Previous serial clock level.
	logic        cs_d;                   // Previous chip select level.
	// Power-up counters.
	logic [3:0]  por_cnt;
	logic [31:0] puw_cnt;
	// Mode and status state.
	logic        four_lane_cmd_mode;                    // Four-lane command mode.
	logic        write_enable_latch;                    // Write enable latch.
	logic        busy;                   // Operation in progress.
	logic        paused;                 // Operation suspended.
	logic        dpd;                    // Deep power-down.
	logic        rst_en;                 // Reset enable armed.
	logic [2:0]  bg;                     // Block guard bits.
	logic        tb;                     // Top/bottom select.
	logic        sec;                    // Small region select.
	logic [1:0]  slm;                    // Status lock mode.
	logic        qe;                     // Quad lane enable.
	logic        inv;                    // Protect invert.
	// Frame state.
	sfmp_phase_e ph;
	logic [7:0]  opc;
	logic [7:0]  sh;
	logic [3:0]  cnt;
	logic [2:0]  bcnt;
	logic [23:0] addr;
	logic [7:0]  wr1;
	logic [7:0]  wr2;
	logic [7:0]  tx;
	logic [3:0]  txc;
	// Operation timer and program drain control.
	logic [31:0] tmr;
	logic        prog_run;
	// FIFO side signals, declared ahead of the terms that read them.
	wire [7:0]   f_data;
	wire         f_valid;
	wire         f_in_rdy;

	// Edge detection works from either idle level, so modes 0 and 3 both fit.
	wire       sck_q    = s2[5];
	wire       cs_q     = s2[4];
	wire [3:0] lane_q   = s2[3:0];
	wire       sel      = !cs_q;
	wire       sck_rise = sel && sck_q && !sck_d;  // see [R3]
	wire       sck_fall = sel && !sck_q && sck_d;  // see [R3]
	wire       cs_rise  = cs_q && !cs_d;
	wire       por_done = (por_cnt == POR_CYC);
	wire       puw_done = (puw_cnt >= PUW_CYC);

	// Status bytes as read out.
	wire [7:0] st1 = {slm[0], sec, tb, bg, write_enable_latch, busy};         // see [R19]
	wire [7:0] st2 = {paused, inv, RSVD_BITS, qe, slm[1]};     // see [R20]

	// Receive width: opcode one lane, or four in four-lane mode.
	wire       dat_q  = (ph == PH_DAT) && (opc == OP_QPP);      // see [R5]
	wire       dat_d  = (ph == PH_DAT) && (opc == OP_DPP);      // see [R4]
	wire [2:0] rx_w   = (four_lane_cmd_mode || dat_q) ? 3'd4 : (dat_d ? 3'd2 : 3'd1);  // see [R7]
	wire [3:0] cnt_nx = cnt + {1'b0, rx_w};
	wire [7:0] sh_nx  = (rx_w == 3'd4) ? {sh[3:0], lane_q} :
	                    (rx_w == 3'd2) ? {sh[5:0], lane_q[1:0]} : {sh[6:0], lane_q[0]};  // see [R1]
	wire       byte_dn = sck_rise && (cnt_nx == 4'd8);
	wire       opc_dn  = byte_dn && (ph == PH_OPC);

	// Command filter applied when an opcode completes.
	wire ob_rd    = (sh_nx == OP_RDSR1) || (sh_nx == OP_RDSR2);
	wire ob_adr   = (sh_nx == OP_PP) || (sh_nx == OP_QPP) || (sh_nx == OP_DPP) ||
	                (sh_nx == OP_SE) || (sh_nx == OP_BE);
	wire ob_busy  = ob_rd || (sh_nx == OP_SUSP) || (sh_nx == OP_RSTEN) || (sh_nx == OP_RST);
	wire ob_known = ob_busy || ob_adr || (sh_nx == OP_WRSR) || (sh_nx == OP_WRDI) ||
	                (sh_nx == OP_WREN) || (sh_nx == OP_EQPI) || (sh_nx == OP_RESM) ||
	                (sh_nx == OP_DPD) || (sh_nx == OP_CE) || (sh_nx == OP_DQPI) ||
	                (sh_nx == OP_DQPI2) || (sh_nx == OP_RDP);
	wire ob_qgate = (sh_nx == OP_QPP) ? qe : ((sh_nx == OP_EQPI) ? (qe && !four_lane_cmd_mode) : 1'b1);  // see [R5] [R6]
	wire ob_acc   = por_done &&                                                  // see [R10]
	                (dpd ? (sh_nx == OP_RDP) :                                   // see [R14]
	                 (busy ? ob_busy : (ob_known && ob_qgate)));                 // see [R15] [R17]

	// Protected range decode from guard, region, direction and invert bits.
	wire [24:0] span_b = SPAN_BLOCK << (bg - 3'd1);
	wire [24:0] span_s = bg[2] ? SPAN_SEC_MAX : (SPAN_SECTOR << (bg - 3'd1));
	wire [24:0] span   = sec ? span_s : span_b;
	wire [24:0] a25    = {1'b0, addr};
	wire        in_rng = (bg == 3'd7) || ((bg != 3'd0) &&
	                     (tb ? (a25 < span) : (a25 >= ARRAY_TOP - span)));  // see [R21] [R25]
	wire        prot_hit = in_rng ^ inv;
	wire        prot_any = inv ? (bg != 3'd7) : (bg != 3'd0);

	// Frame end execution terms; commands act at chip select rise.
	wire ex       = cs_rise && (ph == PH_WT || ph == PH_ADR || ph == PH_DAT);
	wire wr_ok    = write_enable_latch && puw_done;                                          // see [R11] [R12]
	wire wp_lvl   = qe ? 1'b1 : lane_q[2];
	wire unlocked = (slm == 2'b00) || ((slm == 2'b01) && wp_lvl);             // see [R22] [R23]
	wire ex_pp    = ex && (ph == PH_DAT) && (opc == OP_PP || opc == OP_QPP || opc == OP_DPP) && wr_ok;
	wire ex_er    = ex && (ph == PH_WT) && (opc == OP_SE || opc == OP_BE) && wr_ok;
	wire ex_ce    = ex && (ph == PH_WT) && (opc == OP_CE) && wr_ok;
	wire ex_ws    = ex && (ph == PH_DAT) && (opc == OP_WRSR) && (bcnt != 3'd0) && wr_ok && unlocked;
	wire ex_rst   = ex && (opc == OP_RST) && rst_en;
	wire blocked  = ((ex_pp || ex_er) && prot_hit) || (ex_ce && prot_any);   // see [R27]
	wire start    = (ex_pp || ex_er || ex_ce) && !blocked;
	wire drained  = !f_valid && !prog_valid;
	wire op_done  = busy && !paused && (tmr == 32'd0) && drained;             // see [R16]
	wire push     = byte_dn && (ph == PH_DAT) && (opc != OP_WRSR);
	wire flush    = ex_rst || cs_rise && (ph == PH_DAT) && (opc != OP_WRSR) && !start;
	wire f_ready  = prog_run && (!prog_valid || prog_ready);

	// Program data buffer; its full flag drops bytes the host overruns with.
	sfmp_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
		.clk(mclk),
		.rst(rst),
		.flush(flush),
		.in_data(sh_nx),
		.in_valid(push),
		.in_ready(f_in_rdy),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	// Two-stage synchronisers and previous levels for edge detection.
	always_ff @(posedge mclk)
	begin
		s1    <= {sck_pin, cs_n_pin, lane_in};
		s2    <= s1;
		sck_d <= s2[5];
		cs_d  <= s2[4];
	end

	// Power-on window and power-up write delay.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			por_cnt <= '0;
			puw_cnt <= '0;
		end
		else
		begin
			if (!por_done)
				por_cnt <= por_cnt + 4'd1;
			if (!puw_done)
				puw_cnt <= puw_cnt + 32'd1;
		end
	end

	// Receive shifter and frame phase.
	always_ff @(posedge mclk)
	begin
		if (rst || !sel)
		begin
			ph   <= PH_OPC;
			cnt  <= '0;
			bcnt <= '0;
			sh   <= '0;
		end
		else if (sck_rise && ph != PH_IGN && ph != PH_RD)
		begin
			sh  <= sh_nx;
			cnt <= byte_dn ? 4'd0 : cnt_nx;
			if (opc_dn)
			begin
				// Refused opcodes leave the rest of the frame ignored.
				ph   <= !ob_acc ? PH_IGN : ob_rd ? PH_RD : ob_adr ? PH_ADR :
				        (sh_nx == OP_WRSR) ? PH_DAT : PH_WT;
				bcnt <= '0;
			end
			else if (byte_dn)
			begin
				bcnt <= (bcnt == 3'd7) ? bcnt : bcnt + 3'd1;
				if (ph == PH_ADR && bcnt == 3'd2)
					ph <= (opc == OP_SE || opc == OP_BE) ? PH_WT : PH_DAT;
			end
		end
	end

	// Opcode, address and status write bytes.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			opc  <= '0;
			addr <= '0;
			wr1  <= '0;
			wr2  <= '0;
		end
		else if (opc_dn)
			opc <= sh_nx;
		else if (byte_dn && ph == PH_ADR)
			addr <= {addr[15:0], sh_nx};
		else if (byte_dn && ph == PH_DAT && opc == OP_WRSR)
		begin
			if (bcnt == 3'd0)
				wr1 <= sh_nx;
			else if (bcnt == 3'd1)
				wr2 <= sh_nx;
		end
	end

	// Status read output, refreshed each byte so busy can be polled.
	always_ff @(posedge mclk)
	begin
		if (rst || !sel)
		begin
			tx       <= '0;
			txc      <= '0;
			lane_out <= '0;
			lane_oe  <= '0;
		end
		else if (opc_dn)
			tx <= (sh_nx == OP_RDSR2) ? st2 : st1;
		else if (sck_fall && ph == PH_RD)
		begin
			lane_out <= four_lane_cmd_mode ? tx[7:4] : {2'b00, tx[7], 1'b0};  // see [R2]
			lane_oe  <= four_lane_cmd_mode ? OE_QPI : OE_SPI;                   // see [R4] [R8]
			if (txc + (four_lane_cmd_mode ? 4'd4 : 4'd1) == 4'd8)
			begin
				txc <= '0;
				tx  <= (opc == OP_RDSR2) ? st2 : st1;
			end
			else
			begin
				txc <= txc + (four_lane_cmd_mode ? 4'd4 : 4'd1);
				tx  <= four_lane_cmd_mode ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
			end
		end
	end

	// Mode flags; lane usage changes only at frame end.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			four_lane_cmd_mode    <= 1'b0;   // see [R9]
			dpd    <= 1'b0;
			rst_en <= 1'b0;
		end
		else if (ex)
		begin
			rst_en <= (opc == OP_RSTEN);                                        // see [R17]
			if (ex_rst || opc == OP_DQPI || opc == OP_DQPI2)
				four_lane_cmd_mode <= 1'b0;                                                    // see [R8] [R9] [R26]
			else if (opc == OP_EQPI)
				four_lane_cmd_mode <= 1'b1;                                                    // see [R6] [R26]
			if (opc == OP_DPD)
				dpd <= 1'b1;
			else if (opc == OP_RDP)
				dpd <= 1'b0;                                                    // see [R14]
		end
	end

	// Write enable latch.
	always_ff @(posedge mclk)
	begin
		if (rst || ex_rst)
			write_enable_latch <= 1'b0;
		else if (ex && opc == OP_WREN && puw_done)
			write_enable_latch <= 1'b1;                                                        // see [R11] [R12]
		else if ((ex && opc == OP_WRDI) || op_done || blocked)
			write_enable_latch <= 1'b0;                                                        // see [R13]
	end

	// Busy, suspend and the operation timer.
	always_ff @(posedge mclk)
	begin
		if (rst || ex_rst)
		begin
			busy     <= 1'b0;
			paused   <= 1'b0;
			prog_run <= 1'b0;
			tmr      <= '0;
		end
		else if (start || ex_ws)
		begin
			busy     <= 1'b1;                                                   // see [R15]
			prog_run <= ex_pp;
			tmr      <= ex_ws ? WRSR_CYC : (ex_pp ? PROG_CYC : (ex_ce ? CHIP_CYC : ERS_CYC));
		end
		else if (ex && opc == OP_SUSP && busy)
		begin
			busy   <= 1'b0;
			paused <= 1'b1;                                                     // see [R24]
		end
		else if (ex && opc == OP_RESM && paused)
		begin
			busy   <= 1'b1;
			paused <= 1'b0;                                                     // see [R24]
		end
		else if (op_done)
		begin
			busy     <= 1'b0;                                                   // see [R16]
			prog_run <= 1'b0;
		end
		else if (busy && tmr != 32'd0)
			tmr <= tmr - 32'd1;
	end

	// Protection and configuration bits, written by an accepted status write.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			{slm, sec, tb, bg} <= '0;                                           // see [R21] [R25]
			{inv, qe}          <= '0;
		end
		else if (ex_ws)
		begin
			{slm[0], sec, tb, bg} <= wr1[7:2];                                  // see [R19]
			if (bcnt != 3'd1)
				{inv, qe, slm[1]} <= {wr2[6], wr2[1:0]};                        // see [R20]
		end
	end

	// Array hand-off: start pulse, and program bytes drained only when running.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			op_start   <= 1'b0;
			op_kind    <= '0;
			op_addr    <= '0;
			prog_valid <= 1'b0;
			prog_data  <= '0;
		end
		else
		begin
			op_start <= start;
			if (start)
			begin
				op_kind <= ex_pp ? OPK_PROG : (ex_ce ? OPK_CHIP : OPK_ERASE);
				op_addr <= addr;
			end
			if (!prog_valid || prog_ready)
			begin
				prog_valid <= f_valid && prog_run && !ex_rst;
				prog_data  <= f_data;
			end
		end
	end

	// Checks on the guarded behaviour.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_wel_from_wren: assert property ($rose(write_enable_latch) |-> $past(ex) && $past(opc) == OP_WREN) // see [R12]
		else $error("write latch set without write enable");
	a_qpi_needs_qe: assert property ($rose(four_lane_cmd_mode) |-> $past(qe) && $past(cs_rise)) // see [R6] [R26]
		else $error("four-lane mode entered without enable or mid-frame");
	a_por_refuses: assert property (opc_dn && !por_done |=> ph == PH_IGN) // see [R10]
		else $error("command taken during power-on reset");
	a_puw_no_wel: assert property (!puw_done |-> !write_enable_latch) // see [R11]
		else $error("write latch set inside power-up delay");
	a_busy_filters: assert property (opc_dn && busy && sh_nx == OP_WREN |=> ph == PH_IGN) // see [R15]
		else $error("write enable taken while busy");
	a_dpd_filters: assert property (opc_dn && dpd && sh_nx != OP_RDP |=> ph == PH_IGN) // see [R14]
		else $error("command taken in deep power-down");
	a_reset_mode: assert property (ex_rst |=> !four_lane_cmd_mode && !busy && !write_enable_latch) // see [R9] [R17]
		else $error("software reset left state behind");
	a_lock_holds: assert property (slm[1] && cs_rise |=> $stable({bg, tb, sec, slm, qe, inv})) // see [R23]
		else $error("locked status bits changed");
	a_spi_one_lane: assert property (lane_oe != 4'h0 && !four_lane_cmd_mode |-> lane_oe == OE_SPI) // see [R2] [R8]
		else $error("extra lanes driven outside four-lane mode");
	a_out_on_fall: assert property ($changed(lane_out) && sel |-> $past(sck_fall)) // see [R2]
		else $error("read lane changed off a falling edge");
	a_prot_no_busy: assert property (blocked |=> !busy ##1 !busy) // see [R27]
		else $error("protected target left busy set");
	c_enter_qpi: cover property ($rose(four_lane_cmd_mode));
	c_busy_ends: cover property ($fell(busy) && !paused);
	c_suspend: cover property ($rose(paused));
	c_status_read: cover property (sck_fall && ph == PH_RD && busy);
endmodule
`default_nettype wire

// ==== sfmp_host.sv ====
// Behavioural SPI host that drives the serial pins of the flash core.
// Assumes the bench resolves each lane and feeds the wire level back.
`timescale 1ns/1ps
`default_nettype none
module sfmp_host (
	output logic            sck = 1'h0,
	output logic            cs_n = 1'h1,
	output logic [3:0]      h_out = 4'hF,
	output logic [3:0]      h_oe = 4'h0,
	input  wire logic [3:0] lanes
);
	logic [7:0] tx_q[$];     // Bytes for the next frame.
	logic [7:0] rx;          // Last byte read back.
	logic       idle = 1'h0; // Clock level between frames, high in mode 3.

	// One frame: bytes below nw are written, the rest are read back.
	// The clock only moves inside a frame, so idle level marks the mode.
	task automatic frame(input bit quad, input int nw, input int n);
		int k;
		logic [7:0] b;
		sck = idle;
		#32 cs_n = 1'h0;
		for (int i = 0; i < n; i++)
		begin
			b = (i < nw) ? tx_q[i] : 8'h00;
			for (k = quad ? 4 : 7; k >= 0; k -= quad ? 4 : 1)
			begin
				#32 sck = 1'h0;
				// Lanes two and three stay high as released protect and pause pins.
				h_oe = (i >= nw) ? 4'h0 : quad ? 4'hF : 4'hD;
				h_out = quad ? b[k+:4] : {3'h7, b[k]};
				#32 sck = 1'h1;
				rx = quad ? {rx[3:0], lanes} : {rx[6:0], lanes[1]};
			end
		end
		#32 sck = idle;
		#32 cs_n = 1'h1;
		h_oe = 4'h0;
		tx_q.delete();
		#64;
	endtask
endmodule
`default_nettype wire

// ==== sfmp_core_tb.sv ====
// Self-checking bench for the flash mode and protection core.
// Assumes the host model owns the pins and the bench plays the array.
`timescale 1ns/1ps
`default_nettype none
module sfmp_core_tb;
	import sfmp_pkg::*;
	logic        mclk = 1'h0;       // Core clock, 5 ns period.
	logic        rst = 1'h1;        // Power-up reset.
	logic        flip = 1'h0;       // Pattern shown on undriven lanes.
	logic        prog_ready = 1'h0; // Random array back-pressure.
	logic        sck;               // Serial clock from the host.
	logic        cs_n;              // Chip select, active low.
	logic [3:0]  h_out;             // Host lane values.
	logic [3:0]  h_oe;              // Host lane enables.
	logic [3:0]  lane_in;           // Resolved lane levels.
	logic [3:0]  lane_out;          // Device lane values.
	logic [3:0]  lane_oe;           // Device lane enables.
	logic        op_start;          // Operation start pulse.
	logic [1:0]  op_kind;           // Kind of started operation.
	logic [23:0] op_addr;           // Address of started operation.
	logic [7:0]  prog_data;         // Program byte to the array.
	logic        prog_valid;        // Program byte valid.
	logic [7:0]  pd;                // Random program byte.
	logic [7:0]  exp_q[$];          // Program bytes the model expects.
	logic [7:0]  got_q[$];          // Program bytes seen at the hand-off.
	logic [25:0] op_q[$];           // Kind and address per started operation.
	int          mismatches = 0;
	int          comparisons = 0;

	// Whoever enables a lane sets it; a lane nobody drives toggles.
	assign lane_in = (lane_oe & lane_out) | (~lane_oe & h_oe & h_out) | (~lane_oe & ~h_oe & {4{flip}});

	initial
		forever #2.5 mclk = ~mclk;

	sfmp_host host_i (.sck(sck), .cs_n(cs_n), .h_out(h_out), .h_oe(h_oe), .lanes(lane_in));

	// Timers are shortened; erase is long so commands land while busy.
	sfmp_core #(.PUW_CYC(150), .PROG_CYC(30), .ERS_CYC(2000), .CHIP_CYC(50), .WRSR_CYC(400)) sfmp_core_i (
		.mclk(mclk), .rst(rst), .sck_pin(sck), .cs_n_pin(cs_n), .lane_in(lane_in),
		.lane_out(lane_out), .lane_oe(lane_oe), .op_start(op_start), .op_kind(op_kind),
		.op_addr(op_addr), .prog_data(prog_data), .prog_valid(prog_valid), .prog_ready(prog_ready));

	// The array side stalls at random.
	always @(negedge mclk)
	begin
		flip <= ~flip;
		prog_ready <= 1'($urandom);
	end

	// Record what reaches the array.
	always @(posedge mclk)
	begin
		if (op_start === 1'h1)
			op_q.push_back({op_kind, op_addr});
		if (prog_valid === 1'h1 && prog_ready === 1'h1)
			got_q.push_back(prog_data);
	end

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic chk_op(input logic [25:0] got, input logic [25:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: operation %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic send(input logic [39:0] w, input int n, input bit quad = 1'h0);
		for (int i = 0; i < n; i++)
			host_i.tx_q.push_back(w[39-8*i -: 8]);
		host_i.frame(quad, n, n);
	endtask

	task automatic rd(input logic [7:0] op, input logic [7:0] exp, input bit quad = 1'h0);
		host_i.tx_q = '{op};
		host_i.frame(quad, 1, 2);
		chk_byte(host_i.rx, exp);
	endtask

	// Polls the live status until busy drops, bounded.
	task automatic poll();
		host_i.rx = 8'h01;
		for (int i = 0; i < 60 && host_i.rx[0] !== 1'h0; i++)
		begin
			host_i.tx_q = '{OP_RDSR1};
			host_i.frame(1'h0, 1, 2);
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#400_000;
		mismatches++;
		wrap_up();
	end

	initial
	begin
		void'($urandom(32'hf13b_ecc1));
		repeat (6) @(negedge mclk);
		rst = 1'h0;
		send({OP_WREN, 32'h0}, 1);
		rd(OP_RDSR1, 8'h00);
		rd(OP_RDSR2, 8'h00);
		send({OP_WREN, 32'h0}, 1);
		rd(OP_RDSR1, 8'h02);
		send({OP_WRSR, 16'h0402, 16'h0}, 3);
		rd(OP_RDSR1, 8'h07);
		poll();
		rd(OP_RDSR1, 8'h04);
		rd(OP_RDSR2, 8'h02);
		send({OP_WREN, 32'h0}, 1);
		send({OP_SE, 24'hFC_0000, 8'h0}, 4);
		rd(OP_RDSR1, 8'h04);
		// Mode 3 program of 17 bytes: the FIFO keeps 16 and drops the last.
		host_i.idle = 1'h1;
		send({OP_WREN, 32'h0}, 1);
		host_i.tx_q = '{OP_PP, 8'h00, 8'h10, 8'h00};
		for (int i = 0; i < 17; i++)
		begin
			pd = 8'($urandom);
			host_i.tx_q.push_back(pd);
			if (i < 16)
				exp_q.push_back(pd);
		end
		host_i.frame(1'h0, 21, 21);
		poll();
		host_i.idle = 1'h0;
		chk_op(op_q.pop_front(), {OPK_PROG, 24'h00_1000});
		chk_byte(8'(got_q.size()), 8'h10);
		foreach (exp_q[i])
			chk_byte(got_q[i], exp_q[i]);
		rd(OP_RDSR1, 8'h04);
		send({OP_WREN, 32'h0}, 1);
		send({OP_SE, 24'h00_2000, 8'h0}, 4);
		send({OP_WREN, 32'h0}, 1);
		poll();
		rd(OP_RDSR1, 8'h04);
		chk_op(op_q.pop_front(), {OPK_ERASE, 24'h00_2000});
		send({OP_WREN, 32'h0}, 1);
		send({OP_BE, 24'h01_0000, 8'h0}, 4);
		send({OP_SUSP, 32'h0}, 1);
		rd(OP_RDSR2, 8'h82);
		send({OP_RESM, 32'h0}, 1);
		rd(OP_RDSR2, 8'h02);
		poll();
		send({OP_RSTEN, 32'h0}, 1);
		send({OP_RST, 32'h0}, 1);
		rd(OP_RDSR1, 8'h04);
		chk_op(op_q.pop_front(), {OPK_ERASE, 24'h01_0000});
		send({OP_DPD, 32'h0}, 1);
		send({OP_WREN, 32'h0}, 1);
		send({OP_RDP, 32'h0}, 1);
		rd(OP_RDSR1, 8'h04);
		// Enter four-lane mode, then leave it by each way out.
		for (int i = 0; i < 3; i++)
		begin
			send({OP_EQPI, 32'h0}, 1);
			rd(OP_RDSR1, 8'h04, 1'h1);
			if (i == 2)
				send({OP_RSTEN, 32'h0}, 1, 1'h1);
			send({i == 0 ? OP_DQPI : i == 1 ? OP_DQPI2 : OP_RST, 32'h0}, 1, 1'h1);
			rd(OP_RDSR1, 8'h04);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
